//--- tb/tb_tbattr_handler.sv
`timescale 1ns/1ns
module tb_tbattr_handler;
	import tbattr_pkg::*;
	localparam logic [31:0] pupiVal = 32'hA5C3_5A17;
	logic        clock, rst_b, rxValid, rxFrameEnd, txReady, txValid, txLast, selected;
	logic [7:0]  rxByte, txByte, tr0Fs, tr1Fs, wb_adr_i;
	logic [3:0]  frameLimitCode, wb_sel_i;
	logic [1:0]  rateCode;
	logic        sofEnable, eofEnable, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	int          error_cnt, samples_checked;
	logic [7:0]  p1s[4] = '{8'hF3, 8'h5C, 8'h90, 8'hA4};
	logic [7:0]  p2s[4] = '{8'h08, 8'h55, 8'h06, 8'h57};
	logic [31:0] sts[4] = '{32'h0050_4081, 32'h0320_2055, 32'h0040_1061, 32'h0208_0875};
	tbattr_handler u_dut (.clock(clock), .rst_b(rst_b), .rxValid(rxValid), .rxByte(rxByte),
		.rxFrameEnd(rxFrameEnd), .txReady(txReady), .txValid(txValid), .txByte(txByte),
		.txLast(txLast), .selected(selected), .frameLimitCode(frameLimitCode),
		.rateCode(rateCode), .tr0Fs(tr0Fs), .tr1Fs(tr1Fs), .sofEnable(sofEnable),
		.eofEnable(eofEnable), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o));
	tbattr_reader_model u_rdr (.clock(clock), .rst_b(rst_b), .txValid(txValid), .txByte(txByte),
		.txLast(txLast), .rxValid(rxValid), .rxByte(rxByte), .rxFrameEnd(rxFrameEnd),
		.txReady(txReady));
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	task automatic end_of_test;
		if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dw);
		int n;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dw;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clock);
		if (n >= 20) begin
			error_cnt++;
			end_of_test();
		end
	endtask
	task automatic attr(input logic [7:0] cmd, p1, p2, p3, p4, input logic [31:0] id,
		input logic [7:0] flip, input int extra, input bit acc);
		logic [7:0]  q[$];
		logic [7:0]  one[$];
		logic [15:0] c;
		int          n;
		q = {cmd, id[7:0], id[15:8], id[23:16], id[31:24], p1, p2, p3, p4};
		if (extra > 0) q.push_back(8'h00);
		if (extra < 0) void'(q.pop_back());
		one.push_back(8'h10);
		c = u_rdr.crcOf(one);
		u_rdr.got.delete();
		u_rdr.send(q, flip);
		n = 0;
		while (u_rdr.got.size() < 3 && n < 40) begin
			@(posedge clock);
			n++;
		end
		if (acc && u_rdr.got.size() < 3) begin
			error_cnt++;
			end_of_test();
		end
		chk(u_rdr.got.size(), acc ? 3 : 0);
		if (acc && u_rdr.got.size() == 3) begin
			chk(u_rdr.got[0], {1'b0, 8'h10});
			chk(u_rdr.got[1], {1'b0, c[7:0]});
			chk(u_rdr.got[2], {1'b1, c[15:8]});
		end
		@(posedge clock);
	endtask
	initial begin
		error_cnt = 0;
		samples_checked = 0;
		rst_b = 1'b0;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
		wb_sel_i = 4'hF;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		chk({tr1Fs, tr0Fs, selected, sofEnable, eofEnable}, {8'h50, 8'h40, 3'h3});
		wb(1'b0, 8'h00, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		wb(1'b1, 8'h00, pupiVal);
		wb(1'b0, 8'h00, 32'h0000_0000);
		chk(rd, pupiVal);
		wb_sel_i <= 4'h2;
		wb(1'b1, 8'h00, 32'hFFFF_FFFF);
		wb_sel_i <= 4'hF;
		wb(1'b0, 8'h00, 32'h0000_0000);
		chk(rd, {pupiVal[31:16], 8'hFF, pupiVal[7:0]});
		wb(1'b1, 8'h00, pupiVal);
		wb(1'b1, 8'h10, 32'hFFFF_FFFF);
		wb(1'b0, 8'h10, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		wb(1'b1, 8'h08, 32'hFFFF_FFFF);
		wb(1'b0, 8'h08, 32'h0000_0000);
		chk(rd, 32'h0050_4000);
		attr(8'h1E, 8'h00, 8'h08, 8'h01, 8'h00, pupiVal, 8'h00, 0, 0);
		attr(8'h1D, 8'h00, 8'h48, 8'h01, 8'h00, pupiVal, 8'h00, 0, 0);
		attr(8'h1D, 8'h00, 8'hA8, 8'h01, 8'h00, pupiVal, 8'h00, 0, 0);
		attr(8'h1D, 8'h00, 8'h04, 8'h01, 8'h00, pupiVal, 8'h00, 0, 0);
		attr(8'h1D, 8'h00, 8'h09, 8'h01, 8'h00, pupiVal, 8'h00, 0, 0);
		attr(8'h1D, 8'h00, 8'h08, 8'h11, 8'h00, pupiVal, 8'h00, 0, 0);
		attr(8'h1D, 8'h00, 8'h08, 8'h00, 8'h00, pupiVal, 8'h00, 0, 0);
		attr(8'h1D, 8'h00, 8'h08, 8'h01, 8'h01, pupiVal, 8'h00, 0, 0);
		attr(8'h1D, 8'h00, 8'h08, 8'h01, 8'h00, ~pupiVal, 8'h00, 0, 0);
		attr(8'h1D, 8'h00, 8'h08, 8'h01, 8'h00, pupiVal, 8'h01, 0, 0);
		attr(8'h1D, 8'h00, 8'h08, 8'h01, 8'h00, pupiVal, 8'h00, 1, 0);
		attr(8'h1D, 8'h00, 8'h08, 8'h01, 8'h00, pupiVal, 8'h00, -1, 0);
		chk(selected, 1'b0);
		for (int i = 0; i < 4; i++) begin
			u_rdr.slow <= i[0];
			attr(8'h1D, p1s[i], p2s[i], 8'h01, {i[0], 7'h70}, pupiVal, 8'h00, 0, 1);
			chk(selected, 1'b1);
			chk({rateCode, frameLimitCode}, {p2s[i][7:6], p2s[i][3:0]});
			chk({tr0Fs, tr1Fs, sofEnable, eofEnable}, {16'h4050, 2'h3});
			wb(1'b0, 8'h08, 32'h0000_0000);
			chk(rd, sts[i]);
		end
		u_rdr.slow <= 1'b0;
		attr(8'h1D, 8'h00, 8'h08, 8'h01, 8'h00, pupiVal, 8'h01, 0, 0);
		chk({selected, rateCode}, 3'h5);
		wb(1'b0, 8'h0C, 32'h0000_0000);
		chk(rd, 32'h000D_0004);
		wb(1'b1, 8'h04, 32'h0000_0001);
		chk(selected, 1'b0);
		end_of_test();
	end
endmodule

//--- tb/tbattr_reader_model.sv
`timescale 1ns/1ns
module tbattr_reader_model (
	input  wire logic       clock,
	input  wire logic       rst_b,
	input  wire logic       txValid,
	input  wire logic [7:0] txByte,
	input  wire logic       txLast,
	output logic            rxValid,
	output logic [7:0]      rxByte,
	output logic            rxFrameEnd,
	output logic            txReady
);
	logic       slow;
	logic [8:0] got[$];
	initial begin
		rxValid = 1'b0;
		rxByte = 8'h00;
		rxFrameEnd = 1'b0;
		txReady = 1'b0;
		slow = 1'b0;
	end
	// Stalls every other cycle when slow
	always @(posedge clock) begin
		txReady <= slow ? ~txReady : rst_b;
		if (txValid === 1'b1 && txReady === 1'b1) begin
			got.push_back({txLast, txByte});
		end
	end
	function automatic logic [15:0] crcOf(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (q[i]) begin
			c = c ^ {8'h00, q[i]};
			for (int k = 0; k < 8; k++) begin
				c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
			end
		end
		return ~c;
	endfunction
	// Frame body, then CRC low and high byte
	task automatic send(input logic [7:0] q[$], input logic [7:0] flip);
		logic [15:0] c;
		c = crcOf(q);
		q.push_back(c[7:0] ^ flip);
		q.push_back(c[15:8]);
		foreach (q[i]) begin
			@(posedge clock);
			rxValid <= 1'b1;
			rxByte <= q[i];
		end
		@(posedge clock);
		rxValid <= 1'b0;
		rxFrameEnd <= 1'b1;
		rxByte <= ~q[q.size() - 1];
		@(posedge clock);
		rxFrameEnd <= 1'b0;
	endtask
endmodule

//--- verilog/tbattr_cfg.svh
`ifndef TBATTR_CFG_SVH
`define TBATTR_CFG_SVH

// ----------------------------------------
// Frame layout and codes
// ----------------------------------------
`define TBATTR_CMD_CODE      8'h1D
`define TBATTR_FRAME_LEN     4'hB
`define TBATTR_LEN_SAT       4'hC
`define TBATTR_ANSWER        8'h10
`define TBATTR_ANSWER_CRC_LO 8'hF9
`define TBATTR_ANSWER_CRC_HI 8'hE0
`define TBATTR_PROTO_BYTE    8'h01
`define TBATTR_CID_NONE      4'h0
`define TBATTR_RATE_106      2'h0
`define TBATTR_RATE_212      2'h1
`define TBATTR_FSC_MIN       4'h5
`define TBATTR_FSC_MAX       4'h8
`define TBATTR_CODE_RSVD     2'h3
`define TBATTR_CODE_ZERO     2'h0

// ----------------------------------------
// CRC_B
// ----------------------------------------
`define TBATTR_CRC_INIT      16'hFFFF
`define TBATTR_CRC_POLY      16'h8408
`define TBATTR_CRC_RESIDUE   16'hF0B8

// ----------------------------------------
// Timing in subcarrier periods
// ----------------------------------------
`define TBATTR_TR0_APPLIED   8'h40
`define TBATTR_TR1_APPLIED   8'h50
`define TBATTR_TR0_C1_106    8'h30
`define TBATTR_TR0_C1_212    8'h20
`define TBATTR_TR0_C2_106    8'h10
`define TBATTR_TR0_C2_212    8'h08
`define TBATTR_TR1_C1_106    8'h40
`define TBATTR_TR1_C1_212    8'h20
`define TBATTR_TR1_C2_106    8'h10
`define TBATTR_TR1_C2_212    8'h08

// ----------------------------------------
// Register map
// ----------------------------------------
`define TBATTR_REG_PUPI      8'h00
`define TBATTR_REG_CTRL      8'h04
`define TBATTR_REG_STATUS    8'h08
`define TBATTR_REG_COUNT     8'h0C
`define TBATTR_PUPI_RESET    32'h0000_0000
`define TBATTR_CTRL_DESEL    0

`endif

//--- verilog/tbattr_crc_b.sv
`timescale 1ns/1ns
`include "tbattr_cfg.svh"

module tbattr_crc_b (
	input  wire logic [15:0] crcIn,
	input  wire logic [7:0]  dataByte,
	output logic      [15:0] crcOut
);
	logic [15:0] stage [0:8];

	assign stage[0] = crcIn;

	// One reflected shift per data bit, LSB first
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_bit
			assign stage[i+1] = (stage[i][0] ^ dataByte[i]) ?
				((stage[i] >> 1) ^ `TBATTR_CRC_POLY) : (stage[i] >> 1);
		end
	endgenerate

	assign crcOut = stage[8];
endmodule

//--- verilog/tbattr_handler.sv
// The implementer's own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ns
`include "tbattr_cfg.svh"

module tbattr_handler
	import tbattr_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic        rxValid,
	input  wire logic [7:0]  rxByte,
	input  wire logic        rxFrameEnd,
	input  wire logic        txReady,
	output logic             txValid,
	output logic [7:0]       txByte,
	output logic             txLast,
	output logic             selected,
	output logic [3:0]       frameLimitCode,
	output logic [1:0]       rateCode,
	output logic [7:0]       tr0Fs,
	output logic [7:0]       tr1Fs,
	output logic             sofEnable,
	output logic             eofEnable,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o
);
	// ----------------------------------------
	// Receive buffer and decode
	// ----------------------------------------
	tbattr_state_t state_q;
	logic [7:0]    rxBuf_q [0:10];
	logic [3:0]    rxCount_q;
	logic [15:0]   rxCrc_q;
	logic [15:0]   rxCrc_d;
	logic [15:0]   txCrcRaw;
	logic [31:0]   pupi_q;
	logic [1:0]    txIdx_q;
	logic [7:0]    reqTr0_q;
	logic [7:0]    reqTr1_q;
	logic          eofOmitReq_q;
	logic          sofOmitReq_q;
	logic [15:0]   acceptCount_q;
	logic [15:0]   dropCount_q;

	wire        inRx      = (state_q == TBATTR_ST_RX);
	wire        takeByte  = rxValid && inRx && (rxCount_q < `TBATTR_FRAME_LEN);
	wire        frameEnd  = rxFrameEnd && inRx;
	wire [7:0]  cmdByte   = rxBuf_q[0];
	wire [31:0] idField   = {rxBuf_q[4], rxBuf_q[3], rxBuf_q[2], rxBuf_q[1]};
	wire [7:0]  timingOptionByte  = rxBuf_q[5];
	wire [7:0]  rateFramesizeByte = rxBuf_q[6];
	wire [7:0]  protocolTypeByte  = rxBuf_q[7];
	wire [7:0]  cardNumberByte    = rxBuf_q[8];
	wire [1:0]  rateToReader = rateFramesizeByte[7:6];
	wire [1:0]  rateToTag    = rateFramesizeByte[5:4];
	wire [3:0]  readerFsc    = rateFramesizeByte[3:0];

	wire lenOk  = (rxCount_q == `TBATTR_FRAME_LEN);
	wire crcOk  = (rxCrc_q == `TBATTR_CRC_RESIDUE);
	wire cmdOk  = (cmdByte == `TBATTR_CMD_CODE);
	wire idOk   = (idField == pupi_q);
	wire rateOk = (rateToReader <= `TBATTR_RATE_212) && (rateToTag <= `TBATTR_RATE_212);
	wire sameOk = (rateToReader == rateToTag);
	wire fscOk  = (readerFsc >= `TBATTR_FSC_MIN) && (readerFsc <= `TBATTR_FSC_MAX);
	wire p3Ok   = (protocolTypeByte == `TBATTR_PROTO_BYTE);
	wire p4Ok   = (cardNumberByte[3:0] == `TBATTR_CID_NONE);
	wire accept = frameEnd && lenOk && crcOk && cmdOk && idOk && rateOk && sameOk
		&& fscOk && p3Ok && p4Ok;

	// Reserved codes fold to 00b, bits 1-0 unused
	wire [1:0] tr0Sel = (timingOptionByte[7:6] == `TBATTR_CODE_RSVD) ?
		`TBATTR_CODE_ZERO : timingOptionByte[7:6];
	wire [1:0] tr1Sel = (timingOptionByte[5:4] == `TBATTR_CODE_RSVD) ?
		`TBATTR_CODE_ZERO : timingOptionByte[5:4];
	wire       is106  = (rateToReader == `TBATTR_RATE_106);
	wire [7:0] tr0Dec = (tr0Sel == 2'h1) ? (is106 ? `TBATTR_TR0_C1_106 : `TBATTR_TR0_C1_212) :
		(tr0Sel == 2'h2) ? (is106 ? `TBATTR_TR0_C2_106 : `TBATTR_TR0_C2_212) :
		`TBATTR_TR0_APPLIED;
	wire [7:0] tr1Dec = (tr1Sel == 2'h1) ? (is106 ? `TBATTR_TR1_C1_106 : `TBATTR_TR1_C1_212) :
		(tr1Sel == 2'h2) ? (is106 ? `TBATTR_TR1_C2_106 : `TBATTR_TR1_C2_212) :
		`TBATTR_TR1_APPLIED;

	tbattr_crc_b u_rxCrc (
		.crcIn    (rxCrc_q),
		.dataByte (rxByte),
		.crcOut   (rxCrc_d)
	);

	tbattr_crc_b u_txCrc (
		.crcIn    (`TBATTR_CRC_INIT),
		.dataByte (`TBATTR_ANSWER),
		.crcOut   (txCrcRaw)
	);

	wire [15:0] txCrc   = ~txCrcRaw;
	wire        txStep  = txValid && txReady;

	// ----------------------------------------
	// Register bus decode
	// ----------------------------------------
	wire        wbReq     = wb_cyc_i && wb_stb_i;
	wire        wbWrite   = wbReq && wb_we_i && wb_ack_o;
	wire        selPupi   = (wb_adr_i == `TBATTR_REG_PUPI);
	wire        deselect  = wbWrite && (wb_adr_i == `TBATTR_REG_CTRL) && wb_sel_i[0]
		&& wb_dat_i[`TBATTR_CTRL_DESEL];
	wire [31:0] statusWord = {6'h00, sofOmitReq_q, eofOmitReq_q, reqTr1_q, reqTr0_q,
		frameLimitCode, rateCode, 1'b0, selected};
	wire [31:0] readMux = selPupi ? pupi_q :
		(wb_adr_i == `TBATTR_REG_STATUS) ? statusWord :
		(wb_adr_i == `TBATTR_REG_COUNT) ? {dropCount_q, acceptCount_q} :
		32'h0000_0000;

	genvar b;
	generate
		for (b = 0; b < 4; b = b + 1) begin : g_pupiLane
			always_ff @(posedge clock or negedge rst_b) begin
				if (!rst_b)
					pupi_q[8*b +: 8] <= 8'(`TBATTR_PUPI_RESET >> (8*b));
				else if (wbWrite && selPupi && wb_sel_i[b])
					pupi_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
			end
		end
	endgenerate

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wbReq && !wb_ack_o;
			wb_dat_o <= readMux;
		end
	end

	// ----------------------------------------
	// Frame collection
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rxCount_q <= 4'h0;
			rxCrc_q   <= `TBATTR_CRC_INIT;
		end else if (frameEnd || !inRx) begin
			rxCount_q <= 4'h0;
			rxCrc_q   <= `TBATTR_CRC_INIT;
		end else if (rxValid && rxCount_q < `TBATTR_LEN_SAT) begin
			rxCount_q <= rxCount_q + 4'h1;
			if (takeByte)
				rxCrc_q <= rxCrc_d;
		end
	end

	genvar k;
	generate
		for (k = 0; k < 11; k = k + 1) begin : g_rxBuf
			always_ff @(posedge clock or negedge rst_b) begin
				if (!rst_b)
					rxBuf_q[k] <= 8'h00;
				else if (takeByte && rxCount_q == 4'(k))
					rxBuf_q[k] <= rxByte;
			end
		end
	endgenerate

	// ----------------------------------------
	// Selection and answer
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_q  <= TBATTR_ST_RX;
			selected <= 1'b0;
			txValid  <= 1'b0;
			txByte   <= 8'h00;
			txLast   <= 1'b0;
			txIdx_q  <= 2'h0;
		end else begin
			if (accept)
				selected <= 1'b1;
			else if (deselect)
				selected <= 1'b0;
			case (state_q)
				TBATTR_ST_RX: begin
					if (accept) begin
						state_q <= TBATTR_ST_TX;
						txValid <= 1'b1;
						txByte  <= `TBATTR_ANSWER;
						txLast  <= 1'b0;
						txIdx_q <= 2'h0;
					end
				end
				TBATTR_ST_TX: begin
					if (txStep) begin
						txIdx_q <= txIdx_q + 2'h1;
						case (txIdx_q)
							2'h0: begin
								txByte <= txCrc[7:0];
							end
							2'h1: begin
								txByte <= txCrc[15:8];
								txLast <= 1'b1;
							end
							default: begin
								txValid <= 1'b0;
								txLast  <= 1'b0;
								state_q <= TBATTR_ST_RX;
							end
						endcase
					end
				end
				default: begin
					state_q <= TBATTR_ST_RX;
					txValid <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Negotiated settings and counters
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			frameLimitCode <= 4'h0;
			rateCode       <= `TBATTR_RATE_106;
			reqTr0_q       <= `TBATTR_TR0_APPLIED;
			reqTr1_q       <= `TBATTR_TR1_APPLIED;
			eofOmitReq_q   <= 1'b0;
			sofOmitReq_q   <= 1'b0;
		end else if (accept) begin
			frameLimitCode <= readerFsc;
			rateCode       <= rateToReader;
			reqTr0_q       <= tr0Dec;
			reqTr1_q       <= tr1Dec;
			eofOmitReq_q   <= timingOptionByte[3];
			sofOmitReq_q   <= timingOptionByte[2];
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			tr0Fs     <= `TBATTR_TR0_APPLIED;
			tr1Fs     <= `TBATTR_TR1_APPLIED;
			sofEnable <= 1'b1;
			eofEnable <= 1'b1;
		end else begin
			tr0Fs     <= `TBATTR_TR0_APPLIED;
			tr1Fs     <= `TBATTR_TR1_APPLIED;
			sofEnable <= 1'b1;
			eofEnable <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			acceptCount_q <= 16'h0000;
			dropCount_q   <= 16'h0000;
		end else if (accept) begin
			acceptCount_q <= acceptCount_q + 16'h0001;
		end else if (frameEnd) begin
			dropCount_q   <= dropCount_q + 16'h0001;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	sequence s_answerStart;
		txValid && txByte == `TBATTR_ANSWER && !txLast;
	endsequence
	sequence s_crcLow;
		txValid && txByte == `TBATTR_ANSWER_CRC_LO && !txLast;
	endsequence
	sequence s_crcHigh;
		txValid && txByte == `TBATTR_ANSWER_CRC_HI && txLast;
	endsequence
	property p_acceptSelects; accept |=> selected && state_q == TBATTR_ST_TX; endproperty
	a_acceptSelects: assert property (p_acceptSelects) else $error("no select");
	property p_answerCode; accept |=> s_answerStart; endproperty
	a_answerCode: assert property (p_answerCode) else $error("bad answer");
	property p_answerCrc; txStep && txIdx_q == 2'h0 |=> s_crcLow; endproperty
	a_answerCrc: assert property (p_answerCrc) else $error("bad crc lo");
	property p_answerCrcHi; txStep && txIdx_q == 2'h1 |=> s_crcHigh; endproperty
	a_answerCrcHi: assert property (p_answerCrcHi) else $error("bad crc hi");
	property p_badCrcSilent; frameEnd && !crcOk && !txValid |=> !txValid [*3]; endproperty
	a_badCrcSilent: assert property (p_badCrcSilent) else $error("answer on bad crc");
	property p_foreignKeepsSel;
		frameEnd && !idOk && !deselect |=> selected == $past(selected);
	endproperty
	a_foreignKeepsSel: assert property (p_foreignKeepsSel) else $error("state moved");
	property p_rateMismatch; frameEnd && !sameOk && !txValid |=> !txValid; endproperty
	a_rateMismatch: assert property (p_rateMismatch) else $error("answer on rate skew");
	property p_fscSilent; frameEnd && !fscOk && !txValid |=> !txValid; endproperty
	a_fscSilent: assert property (p_fscSilent) else $error("answer on bad size");
	property p_lengthExact; frameEnd && rxCount_q != `TBATTR_FRAME_LEN |=> !txValid; endproperty
	a_lengthExact: assert property (p_lengthExact) else $error("wrong length taken");
	property p_protoCardBytes;
		frameEnd && (protocolTypeByte != `TBATTR_PROTO_BYTE
			|| cardNumberByte[3:0] != `TBATTR_CID_NONE) |=> !txValid;
	endproperty
	a_protoCardBytes: assert property (p_protoCardBytes) else $error("bad protocol taken");
	property p_frameLimit; accept |=> frameLimitCode == $past(readerFsc); endproperty
	a_frameLimit: assert property (p_frameLimit) else $error("limit not kept");
	property p_reservedFold;
		accept && timingOptionByte[7:4] == 4'hF |=> reqTr0_q == `TBATTR_TR0_APPLIED
			&& reqTr1_q == `TBATTR_TR1_APPLIED;
	endproperty
	a_reservedFold: assert property (p_reservedFold) else $error("reserved not folded");
	property p_appliedTiming;
		selected |-> tr0Fs == `TBATTR_TR0_APPLIED && tr1Fs == `TBATTR_TR1_APPLIED
			&& sofEnable && eofEnable;
	endproperty
	a_appliedTiming: assert property (p_appliedTiming) else $error("timing changed");
endmodule

//--- verilog/tbattr_pkg.sv
package tbattr_pkg;
	typedef enum logic [1:0] {
		TBATTR_ST_RX = 2'b00,
		TBATTR_ST_TX = 2'b01
	} tbattr_state_t;
endpackage
